// ===== verilog/aor_audio_out.sv
// audio output path: rate matcher, volume, high-pass, dither, modulators, serial player
`timescale 1ns/1ps
`default_nettype none
module aor_audio_out
  import aor_pkg::*;
#(
  parameter int CONV_DIVIDE = aor_pkg::CONV_DIV
) (
  // clock and reset
  input wire logic I_CLK_SYS,
  input wire logic I_RST,
  // register bus
  input wire logic [aor_pkg::AXI_AW-1:0] I_AWADDR,
  input wire logic I_AWVALID,
  output logic O_AWREADY,
  input wire logic [aor_pkg::AXI_DW-1:0] I_WDATA,
  input wire logic [3:0] I_WSTRB,
  input wire logic I_WVALID,
  output logic O_WREADY,
  output logic [1:0] O_BRESP,
  output logic O_BVALID,
  input wire logic I_BREADY,
  input wire logic [aor_pkg::AXI_AW-1:0] I_ARADDR,
  input wire logic I_ARVALID,
  output logic O_ARREADY,
  output logic [aor_pkg::AXI_DW-1:0] O_RDATA,
  output logic [1:0] O_RRESP,
  output logic O_RVALID,
  input wire logic I_RREADY,
  // sample stream from memory
  input wire logic I_SMP_VALID,
  input wire logic [15:0] I_SMP_LEFT,
  input wire logic [15:0] I_SMP_RIGHT,
  output logic O_SMP_READY,
  // modulator outputs
  output logic O_MOD_LEFT,
  output logic O_MOD_RIGHT,
  // serial audio player
  output logic O_SER_BCLK,
  output logic O_SER_LRCLK,
  output logic O_SER_DATA,
  // path enables for neighbouring blocks
  output logic O_I2S_REC_EN,
  output logic O_ISO_PLAY_EN
);
  logic [7:0] regs [NUM_REGS];
  logic underrun;
  logic bvalid, rvalid;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [13:0] wr_idx, rd_idx;
  logic wr_hit, rd_hit, wr_go, rd_go;
  logic [7:0] div_cnt;
  logic conv_tick;
  logic [19:0] step_raw;
  logic [20:0] step_eff, phase_sum;
  logic [PHASE_W-1:0] phase;
  logic take;
  logic signed [15:0] prev_l, prev_r, cur_l, cur_r, interp_l, interp_r;
  logic signed [15:0] vol_l, vol_r, hp_l, hp_r, mod_in_l, mod_in_r;
  logic signed [31:0] lp_l, lp_r;
  logic [7:0] pwm_cnt;
  logic [4:0] ser_bit;
  logic [3:0] ser_div;
  logic [31:0] ser_shift;

  // ---------------- register bus ----------------
  assign wr_idx = I_AWADDR[AXI_AW-1:2];
  assign rd_idx = I_ARADDR[AXI_AW-1:2];
  assign wr_hit = (wr_idx[13:4] == IDX_PATH_CTRL[13:4]) || (wr_idx == IDX_STATUS);
  assign rd_hit = (rd_idx[13:4] == IDX_PATH_CTRL[13:4]) || (rd_idx == IDX_STATUS);
  // address and data are taken together, only while no response is pending
  assign wr_go = I_AWVALID && I_WVALID && !bvalid;
  assign rd_go = I_ARVALID && !rvalid;
  assign O_AWREADY = wr_go;
  assign O_WREADY = wr_go;
  assign O_ARREADY = rd_go;
  assign O_BVALID = bvalid;
  assign O_BRESP = bresp;
  assign O_RVALID = rvalid;
  assign O_RRESP = rresp;
  assign O_RDATA = rdata;

  always_ff @(posedge I_CLK_SYS) begin
    if (I_RST) begin
      for (int i = 0; i < NUM_REGS; i++) begin
        regs[i] <= REG_RST[i];
      end
    end else if (wr_go && I_WSTRB[0] && wr_idx[13:4] == IDX_PATH_CTRL[13:4]) begin
      regs[wr_idx[3:0]] <= I_WDATA[7:0];
    end
  end

  always_ff @(posedge I_CLK_SYS) begin
    if (I_RST) begin
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
    end else if (wr_go) begin
      bvalid <= 1'b1;
      bresp <= wr_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (I_BREADY) begin
      bvalid <= 1'b0;
    end
  end

  always_ff @(posedge I_CLK_SYS) begin
    if (I_RST) begin
      rvalid <= 1'b0;
      rresp <= RESP_OKAY;
      rdata <= 32'h00000000;
    end else if (rd_go) begin
      rvalid <= 1'b1;
      rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      if (rd_idx == IDX_STATUS) begin
        rdata <= {29'h00000000, underrun, O_MOD_RIGHT, O_MOD_LEFT};
      end else if (rd_hit) begin
        rdata <= {24'h000000, regs[rd_idx[3:0]]};
      end else begin
        rdata <= 32'h00000000;
      end
    end else if (I_RREADY) begin
      rvalid <= 1'b0;
    end
  end

  // sticky underrun: a new miss wins over a write-one clear in the same cycle
  always_ff @(posedge I_CLK_SYS) begin
    if (I_RST) begin
      underrun <= 1'b0;
    end else if (take && !I_SMP_VALID) begin
      underrun <= 1'b1;
    end else if (wr_go && I_WSTRB[0] && wr_idx == IDX_STATUS && I_WDATA[F_UNDERRUN]) begin
      underrun <= 1'b0;
    end
  end

  assign O_I2S_REC_EN = regs[0][F_I2S_REC_EN];
  assign O_ISO_PLAY_EN = regs[0][F_ISO_PLAY_EN];

  // ---------------- converter rate tick and rate matcher ----------------
  always_ff @(posedge I_CLK_SYS) begin
    if (I_RST || conv_tick) begin
      div_cnt <= 8'h00;
    end else begin
      div_cnt <= div_cnt + 8'h01;
    end
  end
  assign conv_tick = (div_cnt == 8'(CONV_DIVIDE - 1));

  assign step_raw = {regs[7], regs[6], regs[5][7:4]};
  // tune byte adds a small unsigned offset to the programmed step
  assign step_eff = {1'b0, step_raw} + {13'h0000, regs[4]};
  assign phase_sum = {2'h0, phase} + step_eff;
  assign take = conv_tick && (phase_sum >= PHASE_WRAP);
  assign O_SMP_READY = take;

  always_ff @(posedge I_CLK_SYS) begin
    if (I_RST) begin
      phase <= '0;
    end else if (conv_tick) begin
      phase <= phase_sum[PHASE_W-1:0];
    end
  end

  // a miss on the stream holds the last sample instead of stalling the converter
  always_ff @(posedge I_CLK_SYS) begin
    if (I_RST) begin
      prev_l <= '0;
      prev_r <= '0;
      cur_l <= '0;
      cur_r <= '0;
    end else if (take && I_SMP_VALID) begin
      prev_l <= cur_l;
      prev_r <= cur_r;
      cur_l <= regs[3][F_I2S_SWAP] ? I_SMP_RIGHT : I_SMP_LEFT;
      cur_r <= regs[3][F_I2S_SWAP] ? I_SMP_LEFT : I_SMP_RIGHT;
    end
  end

  function automatic logic signed [15:0] lerp(input logic signed [15:0] a,
                                              input logic signed [15:0] b,
                                              input logic [7:0] w);
    logic signed [25:0] d;
    d = ($signed({{10{b[15]}}, b}) - $signed({{10{a[15]}}, a})) * $signed({18'h00000, w});
    return 16'(a + 16'(d >>> 8));
  endfunction

  always_ff @(posedge I_CLK_SYS) begin
    if (I_RST) begin
      interp_l <= '0;
      interp_r <= '0;
    end else if (conv_tick) begin
      if (regs[3][F_LINEAR]) begin
        interp_l <= lerp(prev_l, cur_l, phase[PHASE_W-1 -: 8]);
        interp_r <= lerp(prev_r, cur_r, phase[PHASE_W-1 -: 8]);
      end else begin
        interp_l <= cur_l;
        interp_r <= cur_r;
      end
    end
  end

  // ---------------- volume ----------------
  function automatic logic signed [15:0] volume(input logic signed [15:0] x,
                                                input logic [7:0] v);
    logic signed [19:0] p;
    logic signed [51:0] w;
    p = 20'(($signed({{4{x[15]}}, x}) <<< 2) + (v[F_VOL_QUARTER] ? {{4{x[15]}}, x} : 20'h00000)
        + (v[F_VOL_HALF] ? ($signed({{4{x[15]}}, x}) <<< 1) : 20'h00000));
    w = ($signed({{32{p[19]}}, p}) <<< v[6:F_VOL_SHIFT_LO]) >>> VOL_FRAC;
    if (v[F_VOL_MUTE]) begin
      return 16'h0000;
    end else if (w > 52'sh7FFF) begin
      return 16'h7FFF;
    end else if (w < -52'sh8000) begin
      return 16'h8000;
    end
    return w[15:0];
  endfunction

  always_ff @(posedge I_CLK_SYS) begin
    if (I_RST) begin
      vol_l <= '0;
      vol_r <= '0;
    end else if (conv_tick) begin
      vol_l <= volume(interp_l, regs[2]);
      vol_r <= volume(interp_r, regs[2]);
    end
  end

  // ---------------- high-pass: subtract a slow running mean ----------------
  always_ff @(posedge I_CLK_SYS) begin
    if (I_RST) begin
      lp_l <= '0;
      lp_r <= '0;
      hp_l <= '0;
      hp_r <= '0;
    end else if (conv_tick) begin
      lp_l <= lp_l + ((32'(vol_l) <<< HPF_SHIFT) - lp_l) / (2 ** HPF_SHIFT);
      lp_r <= lp_r + ((32'(vol_r) <<< HPF_SHIFT) - lp_r) / (2 ** HPF_SHIFT);
      if (regs[0][F_HPF_EN]) begin
        hp_l <= 16'(vol_l - 16'(lp_l >>> HPF_SHIFT));
        hp_r <= 16'(vol_r - 16'(lp_r >>> HPF_SHIFT));
      end else begin
        hp_l <= vol_l;
        hp_r <= vol_r;
      end
    end
  end

  // mono copies left to both; exchange swaps what each modulator sees
  always_ff @(posedge I_CLK_SYS) begin
    if (I_RST) begin
      mod_in_l <= '0;
      mod_in_r <= '0;
    end else if (conv_tick) begin
      if (regs[0][F_MONO]) begin
        mod_in_l <= hp_l;
        mod_in_r <= hp_l;
      end else if (regs[10][F_MOD_EXCHANGE]) begin
        mod_in_l <= hp_r;
        mod_in_r <= hp_l;
      end else begin
        mod_in_l <= hp_l;
        mod_in_r <= hp_r;
      end
    end
  end

  always_ff @(posedge I_CLK_SYS) begin
    if (I_RST) begin
      pwm_cnt <= 8'h00;
    end else begin
      pwm_cnt <= pwm_cnt + 8'h01;
    end
  end

  // ---------------- dither and modulators, one per channel ----------------
  logic [1:0] mod_bit;
  logic signed [15:0] dith_q [2];
  logic [7:0] cfg_a [2];
  logic [7:0] cfg_b [2];
  logic [1:0] const_sel, shape_sel;
  logic [15:0] const_val [2];
  logic signed [15:0] mod_src [2];

  assign cfg_a[0] = regs[8];
  assign cfg_a[1] = regs[10];
  assign cfg_b[0] = regs[9];
  assign cfg_b[1] = regs[11];
  assign const_sel = {regs[11][F_CONST_R], regs[11][F_CONST_L]};
  assign shape_sel = {regs[3][F_SHAPE_R], regs[3][F_SHAPE_L]};
  assign const_val[0] = {regs[13], regs[12]};
  assign const_val[1] = {regs[15], regs[14]};
  assign mod_src[0] = mod_in_l;
  assign mod_src[1] = mod_in_r;

  function automatic logic signed [15:0] pn_take(input logic [15:0] s, input logic [4:0] n);
    logic [4:0] k;
    logic [16:0] m;
    k = (n > 5'(PN_MAX_BITS)) ? 5'(PN_MAX_BITS) : n;
    m = (17'h00001 << k) - 17'h00001;
    // centre the masked value around zero
    return 16'(({1'b0, s} & m) - (m >> 1));
  endfunction

  for (genvar ch = 0; ch < 2; ch++) begin : g_chan
    logic [15:0] lfsr_a, lfsr_b;
    logic signed [15:0] pn_sum, pn_prev;
    logic signed [19:0] acc;
    logic signed [16:0] pwm_val;
    // first generator enable bit sits in the first config byte for the left
    // channel and in the left channel's second byte for the right channel
    logic en_first, en_second;
    assign en_first = (ch == 0) ? cfg_a[0][F_PN_FIRST_EN] : cfg_b[0][F_PN_FIRST_EN];
    assign en_second = (ch == 0) ? cfg_a[0][F_PN_SECOND_EN] : cfg_b[0][F_PN_SECOND_EN];
    assign pn_sum = 16'((en_first ? pn_take(lfsr_a, cfg_a[ch][4:0]) : 16'h0000)
                  + (en_second ? pn_take(lfsr_b, cfg_b[ch][4:0]) : 16'h0000));

    always_ff @(posedge I_CLK_SYS) begin
      if (I_RST) begin
        lfsr_a <= PN_SEED;
        lfsr_b <= ~PN_SEED;
        pn_prev <= '0;
        dith_q[ch] <= '0;
      end else if (conv_tick) begin
        lfsr_a <= {lfsr_a[14:0], lfsr_a[15] ^ lfsr_a[13] ^ lfsr_a[12] ^ lfsr_a[10]};
        lfsr_b <= {lfsr_b[14:0], lfsr_b[15] ^ lfsr_b[14] ^ lfsr_b[12] ^ lfsr_b[3]};
        pn_prev <= pn_sum;
        if (const_sel[ch]) begin
          dith_q[ch] <= const_val[ch];
        end else if (shape_sel[ch]) begin
          dith_q[ch] <= 16'(pn_sum - pn_prev);
        end else begin
          dith_q[ch] <= pn_sum;
        end
      end
    end

    // first-order loop: error accumulator, sign is the output bit
    always_ff @(posedge I_CLK_SYS) begin
      if (I_RST) begin
        acc <= '0;
      end else if (conv_tick) begin
        acc <= acc + 20'(mod_src[ch]) + 20'(dith_q[ch])
             - (acc[19] ? -20'sh08000 : 20'sh07FFF);
      end
    end

    assign pwm_val = regs[3][F_PWM_NO_X2] ? 17'(mod_src[ch]) : 17'(mod_src[ch]) <<< 1;

    always_ff @(posedge I_CLK_SYS) begin
      if (I_RST) begin
        mod_bit[ch] <= 1'b0;
      end else if (!regs[0][F_MOD_PLAY_EN]) begin
        mod_bit[ch] <= 1'b0;
      end else if (regs[3][F_PWM_EN]) begin
        mod_bit[ch] <= pwm_cnt < (pwm_val[16:9] ^ 8'h80);
      end else begin
        mod_bit[ch] <= ~acc[19];
      end
    end
  end

  assign O_MOD_LEFT = mod_bit[0];
  assign O_MOD_RIGHT = mod_bit[1];

  // ---------------- serial player: 16 bits left then right, MSB first ----------------
  always_ff @(posedge I_CLK_SYS) begin
    if (I_RST || !regs[0][F_I2S_PLAY_EN]) begin
      ser_div <= 4'h0;
      ser_bit <= 5'h00;
      ser_shift <= 32'h00000000;
      O_SER_BCLK <= 1'b0;
      O_SER_LRCLK <= 1'b0;
      O_SER_DATA <= 1'b0;
    end else if (ser_div == regs[5][3:0]) begin
      ser_div <= 4'h0;
      O_SER_BCLK <= ~O_SER_BCLK;
      if (O_SER_BCLK) begin
        ser_bit <= ser_bit + 5'h01;
        O_SER_LRCLK <= ser_bit[4];
        O_SER_DATA <= (ser_bit == 5'h00) ? mod_in_l[15] : ser_shift[31];
        ser_shift <= (ser_bit == 5'h00) ? {mod_in_l[14:0], mod_in_r, 1'b0} : ser_shift << 1;
      end
    end else begin
      ser_div <= ser_div + 4'h1;
    end
  end

  // ---------------- checks ----------------
  default clocking cb @(posedge I_CLK_SYS); endclocking
  default disable iff (I_RST);

  a_step_high_write: assert property (
    (wr_go && I_WSTRB[0] && wr_idx == IDX_STEP_HIGH) |=> step_raw[19:12] == $past(I_WDATA[7:0]))
    else $error("step high byte not loaded");
  a_phase_take: assert property (
    (conv_tick && phase_sum >= PHASE_WRAP && I_SMP_VALID)
      |=> cur_l == ($past(regs[3][F_I2S_SWAP]) ? $past(I_SMP_RIGHT) : $past(I_SMP_LEFT)))
    else $error("sample not taken on phase overflow");
  a_hold_interp: assert property (
    (conv_tick && !regs[3][F_LINEAR]) |=> interp_l == $past(cur_l))
    else $error("hold interpolation mismatch");
  a_left_const: assert property (
    (conv_tick && regs[11][F_CONST_L]) |=> dith_q[0] == {$past(regs[13]), $past(regs[12])})
    else $error("left constant dither wrong");
  a_right_const: assert property (
    (conv_tick && regs[11][F_CONST_R]) |=> dith_q[1] == {$past(regs[15]), $past(regs[14])})
    else $error("right constant dither wrong");
  a_mute_zero: assert property (
    (conv_tick && regs[2][F_VOL_MUTE]) ##1 (regs[2][F_VOL_MUTE]) |-> vol_l == 16'h0000)
    else $error("mute did not silence volume stage");
  a_mod_exchange: assert property (
    (conv_tick && !regs[0][F_MONO] && regs[10][F_MOD_EXCHANGE]) |=> mod_in_l == $past(hp_r))
    else $error("modulator exchange missing");
  a_hpf_bypass: assert property (
    (conv_tick && !regs[0][F_HPF_EN]) |=> hp_r == $past(vol_r))
    else $error("high-pass active while disabled");
endmodule
`default_nettype wire

// ===== verilog/aor_pkg.sv
// constants and register map of the audio output rate-match and modulator block
package aor_pkg;
  // bus geometry
  localparam int AXI_AW = 16;
  localparam int AXI_DW = 32;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // register indices; byte address is four times the index
  localparam logic [13:0] IDX_PATH_CTRL = 14'h0560;
  localparam logic [13:0] IDX_GRP_MID = 14'h0561;
  localparam logic [13:0] IDX_VOLUME = 14'h0562;
  localparam logic [13:0] IDX_INTERP_CTRL = 14'h0563;
  localparam logic [13:0] IDX_STEP_TUNE = 14'h0564;
  localparam logic [13:0] IDX_STEP_LOW = 14'h0565;
  localparam logic [13:0] IDX_STEP_MID = 14'h0566;
  localparam logic [13:0] IDX_STEP_HIGH = 14'h0567;
  localparam logic [13:0] IDX_NOISE_L1 = 14'h0568;
  localparam logic [13:0] IDX_NOISE_L2 = 14'h0569;
  localparam logic [13:0] IDX_NOISE_R1 = 14'h056A;
  localparam logic [13:0] IDX_NOISE_R2 = 14'h056B;
  localparam logic [13:0] IDX_CONST_L_LO = 14'h056C;
  localparam logic [13:0] IDX_CONST_L_HI = 14'h056D;
  localparam logic [13:0] IDX_CONST_R_LO = 14'h056E;
  localparam logic [13:0] IDX_CONST_R_HI = 14'h056F;
  localparam logic [13:0] IDX_STATUS = 14'h0570;
  localparam int NUM_REGS = 16;
  localparam logic [7:0] REG_RST [NUM_REGS] = '{
    8'h04, 8'h40, 8'h40, 8'h64, 8'h01, 8'h90, 8'hC4, 8'h00,
    8'h50, 8'h40, 8'h10, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
  // field positions
  localparam int F_MONO = 0;
  localparam int F_I2S_REC_EN = 1;
  localparam int F_ISO_PLAY_EN = 2;
  localparam int F_MOD_PLAY_EN = 3;
  localparam int F_I2S_PLAY_EN = 4;
  localparam int F_HPF_EN = 7;
  localparam int F_VOL_QUARTER = 0;
  localparam int F_VOL_HALF = 1;
  localparam int F_VOL_SHIFT_LO = 2;
  localparam int F_VOL_MUTE = 7;
  localparam int F_PWM_NO_X2 = 0;
  localparam int F_PWM_EN = 1;
  localparam int F_LINEAR = 2;
  localparam int F_SHAPE_L = 5;
  localparam int F_SHAPE_R = 6;
  localparam int F_I2S_SWAP = 7;
  localparam int F_PN_SECOND_EN = 5;
  localparam int F_PN_FIRST_EN = 6;
  localparam int F_MOD_EXCHANGE = 5;
  localparam int F_CONST_L = 5;
  localparam int F_CONST_R = 6;
  localparam int F_UNDERRUN = 2;
  // rate matcher: phase wraps at this value
  localparam logic [20:0] PHASE_WRAP = 21'h080000;
  localparam int PHASE_W = 19;
  // volume byte 0x40 (shift 16) is unity gain
  localparam int VOL_FRAC = 18;
  localparam int PN_MAX_BITS = 16;
  localparam logic [15:0] PN_SEED = 16'hACE1;
  localparam int HPF_SHIFT = 8;
  // converter clock derived from the 50 MHz system clock
  localparam int SYS_CLK_HZ = 50000000;
  localparam int CONV_CLK_HZ = 6250000;
  localparam int CONV_DIV = SYS_CLK_HZ / CONV_CLK_HZ;
endpackage

// ===== verif/aor_filter_model.sv
// behavioural stand-in for the passive low-pass network fed by one modulator output
`timescale 1ns/1ps
`default_nettype none
module aor_filter_model (
  // clock and window restart
  input wire logic i_clk,
  input wire logic i_clear,
  // modulator bit in, averaged level out
  input wire logic i_bit,
  output logic [15:0] o_ones
);
  // a boxcar count replaces the analog network: the level seen downstream is the
  // density of ones since the last restart, which is all the bench needs to judge
  always_ff @(posedge i_clk) begin
    if (i_clear) begin
      o_ones <= 16'h0000;
    end else if (i_bit) begin
      o_ones <= o_ones + 16'h0001;
    end
  end
endmodule
`default_nettype wire

// ===== verif/test_audio_output_rate_match_sdm.sv
// register, rate-match and modulator output bench for the audio output block
`timescale 1ns/1ps
`default_nettype none
module test_audio_output_rate_match_sdm;
  import aor_pkg::*;
  logic I_CLK_SYS, I_RST, I_AWVALID, I_WVALID, I_BREADY, I_ARVALID, I_RREADY, I_SMP_VALID;
  logic [15:0] I_AWADDR, I_ARADDR, I_SMP_LEFT, I_SMP_RIGHT;
  logic [31:0] I_WDATA;
  logic [3:0] I_WSTRB;
  wire logic O_AWREADY, O_WREADY, O_BVALID, O_ARREADY, O_RVALID, O_SMP_READY;
  wire logic O_MOD_LEFT, O_MOD_RIGHT, O_SER_BCLK, O_SER_LRCLK, O_SER_DATA;
  wire logic O_I2S_REC_EN, O_ISO_PLAY_EN;
  wire logic [1:0] O_BRESP, O_RRESP;
  wire logic [31:0] O_RDATA;
  wire logic [15:0] ones_l, ones_r;
  logic meas_clr, bclk_prev, lr_prev;
  logic [31:0] sr, frame;
  logic [31:0] rd;
  logic [1:0] rs;
  logic [15:0] dl, dr;
  int mismatches, checks, rdy_cnt, rise_cnt, n;
  logic [7:0] cfg [NUM_REGS] = '{8'h08, 8'h40, 8'h40, 8'h04, 8'h00, 8'h03, 8'h00, 8'h40,
    8'h50, 8'h40, 8'h10, 8'h60, 8'h00, 8'h00, 8'h00, 8'h00};

  aor_audio_out #(.CONV_DIVIDE(8)) uut (.I_CLK_SYS(I_CLK_SYS), .I_RST(I_RST),
    .I_AWADDR(I_AWADDR), .I_AWVALID(I_AWVALID), .O_AWREADY(O_AWREADY), .I_WDATA(I_WDATA),
    .I_WSTRB(I_WSTRB), .I_WVALID(I_WVALID), .O_WREADY(O_WREADY), .O_BRESP(O_BRESP),
    .O_BVALID(O_BVALID), .I_BREADY(I_BREADY), .I_ARADDR(I_ARADDR), .I_ARVALID(I_ARVALID),
    .O_ARREADY(O_ARREADY), .O_RDATA(O_RDATA), .O_RRESP(O_RRESP), .O_RVALID(O_RVALID),
    .I_RREADY(I_RREADY), .I_SMP_VALID(I_SMP_VALID), .I_SMP_LEFT(I_SMP_LEFT),
    .I_SMP_RIGHT(I_SMP_RIGHT), .O_SMP_READY(O_SMP_READY), .O_MOD_LEFT(O_MOD_LEFT),
    .O_MOD_RIGHT(O_MOD_RIGHT), .O_SER_BCLK(O_SER_BCLK), .O_SER_LRCLK(O_SER_LRCLK),
    .O_SER_DATA(O_SER_DATA), .O_I2S_REC_EN(O_I2S_REC_EN), .O_ISO_PLAY_EN(O_ISO_PLAY_EN));
  aor_filter_model lpf_l (.i_clk(I_CLK_SYS), .i_clear(meas_clr), .i_bit(O_MOD_LEFT),
    .o_ones(ones_l));
  aor_filter_model lpf_r (.i_clk(I_CLK_SYS), .i_clear(meas_clr), .i_bit(O_MOD_RIGHT),
    .o_ones(ones_r));

  initial begin
    I_CLK_SYS = 1'b0;
    forever #10 I_CLK_SYS = ~I_CLK_SYS;
  end

  always @(posedge I_CLK_SYS) begin
    bclk_prev <= O_SER_BCLK;
    if (O_SMP_READY === 1'b1) rdy_cnt <= rdy_cnt + 1;
    // data and word select are sampled on the bit clock rise; a right-to-left
    // word select step closes a frame of left then right
    if (O_SER_BCLK === 1'b1 && bclk_prev === 1'b0) begin
      rise_cnt <= rise_cnt + 1;
      lr_prev <= O_SER_LRCLK;
      sr <= {sr[30:0], O_SER_DATA};
      if (O_SER_LRCLK === 1'b0 && lr_prev === 1'b1) frame <= sr;
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask

  task automatic in_range(input logic [15:0] v, input int lo, input int hi);
    check({31'h0, (v >= lo) && (v <= hi)}, 32'h1);
  endtask

  // one register access; the request is held until the slave's ready is sampled high
  task automatic bus(input logic wr, input logic [13:0] idx, input logic [31:0] wd,
      input logic [3:0] st);
    int k;
    k = 0;
    @(posedge I_CLK_SYS);
    if (wr) begin
      I_AWADDR <= {idx, 2'b00};
      I_WDATA <= wd;
      I_WSTRB <= st;
      I_AWVALID <= 1'b1;
      I_WVALID <= 1'b1;
      I_BREADY <= 1'b1;
      do @(posedge I_CLK_SYS); while (O_AWREADY !== 1'b1 && ++k < 200);
      I_AWVALID <= 1'b0;
      I_WVALID <= 1'b0;
      do @(posedge I_CLK_SYS); while (O_BVALID !== 1'b1 && ++k < 200);
      rs = O_BRESP;
      I_BREADY <= 1'b0;
    end else begin
      I_ARADDR <= {idx, 2'b00};
      I_ARVALID <= 1'b1;
      I_RREADY <= 1'b1;
      do @(posedge I_CLK_SYS); while (O_ARREADY !== 1'b1 && ++k < 200);
      I_ARVALID <= 1'b0;
      do @(posedge I_CLK_SYS); while (O_RVALID !== 1'b1 && ++k < 200);
      rd = O_RDATA;
      rs = O_RRESP;
      I_RREADY <= 1'b0;
    end
    if (k >= 200) mismatches++;
  endtask

  task automatic wreg(input logic [13:0] idx, input logic [7:0] v);
    bus(1'b1, idx, {24'h0, v}, 4'hF);
  endtask

  // new samples are placed at the edge where the current pair is taken
  task automatic samples(input logic [15:0] l, input logic [15:0] r);
    int k;
    k = 0;
    do @(posedge I_CLK_SYS); while (O_SMP_READY !== 1'b1 && ++k < 500);
    if (k >= 500) mismatches++;
    I_SMP_LEFT <= l;
    I_SMP_RIGHT <= r;
    repeat (300) @(posedge I_CLK_SYS);
  endtask

  task automatic measure();
    @(posedge I_CLK_SYS);
    meas_clr <= 1'b1;
    @(posedge I_CLK_SYS);
    meas_clr <= 1'b0;
    repeat (1000) @(posedge I_CLK_SYS);
    dl = ones_l;
    dr = ones_r;
  endtask

  task automatic count_ready(input int cyc);
    int s;
    s = rdy_cnt;
    repeat (cyc) @(posedge I_CLK_SYS);
    n = rdy_cnt - s;
  endtask

  task automatic report_and_stop();
    $display("checks=%0d mismatches=%0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  initial begin
    #2_000_000;
    mismatches++;
    report_and_stop();
  end

  initial begin
    {I_AWVALID, I_WVALID, I_BREADY, I_ARVALID, I_RREADY, meas_clr} = '0;
    {I_AWADDR, I_ARADDR, I_WDATA, I_WSTRB, I_SMP_LEFT, I_SMP_RIGHT} = '0;
    {mismatches, checks, rdy_cnt, rise_cnt} = '0;
    I_SMP_VALID = 1'b1;
    I_RST = 1'b1;
    repeat (6) @(posedge I_CLK_SYS);
    I_RST <= 1'b0;
    for (int i = 0; i < NUM_REGS; i++) begin
      bus(1'b0, IDX_PATH_CTRL + 14'(i), 32'h0, 4'h0);
      check(rd, {24'h0, REG_RST[i]});
    end
    check({30'h0, O_I2S_REC_EN, O_ISO_PLAY_EN}, 32'h1);
    for (int i = 0; i < NUM_REGS; i++) begin
      bus(1'b1, IDX_PATH_CTRL + 14'(i), 32'hFFFFFF5A ^ 32'(i), 4'hF);
      bus(1'b0, IDX_PATH_CTRL + 14'(i), 32'h0, 4'h0);
      check(rd, {24'h0, 8'h5A ^ 8'(i)});
      if (i == 0) check({30'h0, O_I2S_REC_EN, O_ISO_PLAY_EN}, 32'h2);
      wreg(IDX_PATH_CTRL + 14'(i), cfg[i]);
    end
    bus(1'b1, IDX_VOLUME, 32'hFF, 4'hE);
    bus(1'b0, IDX_VOLUME, 32'h0, 4'h0);
    check(rd, 32'h40);
    bus(1'b0, 14'h0571, 32'h0, 4'h0);
    check({30'h0, rs}, {30'h0, RESP_SLVERR});
    check(rd, 32'h0);
    bus(1'b1, 14'h055F, 32'h1, 4'hF);
    check({30'h0, rs}, {30'h0, RESP_SLVERR});
    $display("test registers done");
    count_ready(1600);
    in_range(16'(n), 99, 101);
    bus(1'b1, IDX_STEP_HIGH, 32'h0, 4'hF);
    count_ready(800);
    check(n, 0);
    wreg(IDX_STEP_TUNE, 8'hFF);
    count_ready(20000);
    in_range(16'(n), 1, 2);
    wreg(IDX_STEP_TUNE, 8'h00);
    wreg(IDX_STEP_HIGH, 8'h40);
    @(posedge I_CLK_SYS);
    I_SMP_VALID <= 1'b0;
    repeat (100) @(posedge I_CLK_SYS);
    I_SMP_VALID <= 1'b1;
    bus(1'b0, IDX_STATUS, 32'h0, 4'h0);
    check(rd[F_UNDERRUN], 1'b1);
    wreg(IDX_STATUS, 8'h04);
    bus(1'b0, IDX_STATUS, 32'h0, 4'h0);
    check(rd[F_UNDERRUN], 1'b0);
    $display("test rate match done");
    samples(16'h4000, 16'hC000);
    measure();
    in_range(dl, 650, 850);
    in_range(dr, 150, 350);
    wreg(IDX_VOLUME, 8'hC0);
    measure();
    in_range(dl, 400, 600);
    wreg(IDX_VOLUME, 8'h40);
    wreg(IDX_NOISE_R1, 8'h30);
    measure();
    in_range(dl, 150, 350);
    wreg(IDX_NOISE_R1, 8'h10);
    wreg(IDX_INTERP_CTRL, 8'h80);
    measure();
    in_range(dl, 150, 350);
    wreg(IDX_INTERP_CTRL, 8'h04);
    wreg(IDX_CONST_L_HI, 8'hC0);
    wreg(IDX_CONST_R_HI, 8'h40);
    measure();
    in_range(dl, 400, 600);
    in_range(dr, 400, 600);
    wreg(IDX_CONST_L_HI, 8'h00);
    wreg(IDX_CONST_R_HI, 8'h00);
    // small noise words keep the modulator out of overload
    wreg(IDX_NOISE_L1, 8'h4C);
    wreg(IDX_NOISE_R1, 8'h0C);
    wreg(IDX_NOISE_R2, 8'h00);
    measure();
    in_range(dl, 650, 850);
    in_range(dr, 150, 350);
    wreg(IDX_INTERP_CTRL, 8'h64);
    measure();
    in_range(dl, 650, 850);
    in_range(dr, 150, 350);
    wreg(IDX_NOISE_R2, 8'h60);
    wreg(IDX_INTERP_CTRL, 8'h06);
    measure();
    in_range(dl, 700, 800);
    in_range(dr, 170, 280);
    wreg(IDX_INTERP_CTRL, 8'h07);
    measure();
    in_range(dl, 590, 670);
    in_range(dr, 330, 420);
    wreg(IDX_INTERP_CTRL, 8'h04);
    wreg(IDX_NOISE_L1, 8'h50);
    wreg(IDX_NOISE_R1, 8'h10);
    wreg(IDX_PATH_CTRL, 8'h09);
    measure();
    in_range(dr, 650, 850);
    wreg(IDX_PATH_CTRL, 8'h00);
    measure();
    check({dl, dr}, 32'h0);
    wreg(IDX_PATH_CTRL, 8'h88);
    repeat (12000) @(posedge I_CLK_SYS);
    measure();
    in_range(dl, 400, 600);
    $display("test modulator done");
    wreg(IDX_PATH_CTRL, 8'h18);
    for (int d = 3; d <= 7; d += 4) begin
      wreg(IDX_STEP_LOW, 8'(d));
      n = rise_cnt;
      repeat (1600) @(posedge I_CLK_SYS);
      in_range(16'(rise_cnt - n), 800 / (d + 1) - 1, 800 / (d + 1) + 1);
      check(frame, 32'h4000C000);
    end
    wreg(IDX_PATH_CTRL, 8'h08);
    n = rise_cnt;
    repeat (400) @(posedge I_CLK_SYS);
    check(rise_cnt - n, 0);
    $display("test serial player done");
    report_and_stop();
  end
endmodule
`default_nettype wire
